// ===== rtl/flash_byte_buffer.sv
module flash_byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,      // System clock
    input  wire logic             reset_i,    // Async reset, active high
    input  wire logic             flush_i,    // Drop all entries
    input  wire logic             in_valid_i, // Write offer
    output logic                  in_ready_o, // Room available
    input  wire logic [WIDTH-1:0] in_data_i,  // Write data
    output logic                  out_valid_o,// Entry available
    input  wire logic             out_ready_i,// Consumer takes entry
    output logic      [WIDTH-1:0] out_data_o  // Head entry
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    // Handshakes
    assign in_ready_o  = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = store_reg[rd_ptr_reg];
    assign push        = in_valid_i & in_ready_o & ~flush_i;
    assign pop         = out_ready_i & out_valid_o & ~flush_i;

    // Entry storage
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            store_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop & ~push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : flash_byte_buffer

// ===== rtl/flash_cmd_pkg.sv
// Notes on behaviour
// (R1) Latch-set opcode sets the write enable latch
// (R2) Host sends latch-set before every modifying command
// (R3) Latch clear refuses writes; latch readable
// (R4) Latch commands are one opcode byte framed
// (R5) Latch-clear opcode clears the write enable latch
// (R6) Latch clears at reset and write completions
// (R7) Status read accepted anytime, repeats while selected
// (R8) Host polls busy bit before new commands
// (R9) Busy bit shows a running internal cycle
// (R10) Protect levels stored, nonzero blocks program/erase
// (R11) Chip erase only with all protect levels zero
// (R12) Lock bit plus low pin rejects status write
// (R13) Status write ends exactly after data byte
// (R14) Status write keeps b6,b5,b1,b0; b6,b5 zero; code stores only data b7 and b4..b2
// (R15) Accepted status write runs timed cycle, clears latch
// (R16) Lock bit zero: pin level never blocks writes
// (R17) Hardware lock follows lock bit and low pin
// (R18) Array read: opcode, 24-bit address, data out
// (R19) Read address increments and wraps to zero
// (R20) Deselect ends read at any bit
// (R21) Array read refused while a cycle runs
// (R22) All transfers most significant bit first
// (R23) Framed commands need whole byte counts
// (R24) Opcodes 06h 04h 05h 01h 03h decoded
package flash_cmd_pkg;
    // Opcodes
    localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD   = 8'h03;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] BLOCK_ERASE_CMD  = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD   = 8'hC7;
    // Status field positions
    localparam int WIP_BIT  = 0;
    localparam int WEL_BIT  = 1;
    localparam int BP_LSB   = 2;
    localparam int BP_MSB   = 4;
    localparam int LOCK_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Byte counts that frame each command
    localparam logic [2:0] ONE_BYTE       = 3'h1;
    localparam logic [2:0] TWO_BYTES      = 3'h2;
    localparam logic [2:0] ADDR_END_BYTE  = 3'h3;
    localparam logic [2:0] ERASE_BYTES    = 3'h4;
    localparam logic [2:0] PROG_MIN_BYTES = 3'h5;
    localparam logic [2:0] BYTE_SAT       = 3'h7;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam int ADDR_W = 24;

    // Raw serial pins as one bundle
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic wp_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, wp_n: 1'b1};

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_WDATA,
        ST_STATUS_OUT,
        ST_DATA_OUT,
        ST_TAIL,
        ST_IGNORE
    } state_t;
endpackage : flash_cmd_pkg

// ===== rtl/serial_flash_status_read.sv
module serial_flash_status_read #(
    parameter int MEM_AW      = 12,   // Stored array address bits
    parameter int BUSY_CYCLES = 1000  // Self-timed cycle length in clocks
) (
    input  wire logic                  clk_i,         // System clock, 100 MHz
    input  wire logic                  reset_i,       // Async reset, active high
    input  wire flash_cmd_pkg::pins_t  pins_i,        // Raw select, clock, data, protect pins
    output logic                       data_out_o,    // Serial data out
    output logic                       data_out_en_o, // High while driving data out
    input  wire logic                  mem_wr_i,      // Array preload strobe
    input  wire logic [MEM_AW-1:0]     mem_addr_i,    // Array preload address
    input  wire logic [7:0]            mem_data_i,    // Array preload data
    output logic [7:0]                 status_o,      // Status byte as read
    output logic                       hw_lock_o,     // Hardware lock mode active
    output logic                       sw_lock_o      // Some protect level set
);
    import flash_cmd_pkg::*;

    localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);

    logic [7:0]        array_mem [2**MEM_AW];
    pins_t             sync1_reg;
    pins_t             sync2_reg;
    pins_t             prev_reg;
    state_t            state_reg;
    logic [7:0]        in_sh_reg;
    logic [2:0]        bitpos_reg;
    logic [2:0]        byte_cnt_reg;
    logic [7:0]        opcode_reg;
    logic [7:0]        wdata_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] fetch_addr_reg;
    logic [7:0]        out_sh_reg;
    logic [2:0]        out_cnt_reg;
    logic              dout_reg;
    logic              wel_reg;
    logic [2:0]        bp_reg;
    logic              lock_reg;
    logic              busy_reg;
    logic [BUSY_W-1:0] busy_cnt_reg;
    logic              pend_wr_reg;
    logic              sel;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_rise;
    logic              byte_done;
    logic [7:0]        in_byte;
    logic              hardware_lock_mode;
    logic              bp_clear;
    logic              aligned;
    logic              exec_set;
    logic              exec_clear;
    logic              exec_status_write_cmd;
    logic              exec_modify;
    logic              start_cycle;
    logic              busy_end;
    logic [7:0]        status_byte;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic [7:0]        buf_out_data;
    logic              out_phase;
    logic              pop;
    logic [7:0]        next_byte;

    // Two-stage pin synchronisers, then a history stage for edges
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= PINS_IDLE;
            sync2_reg <= PINS_IDLE;
            prev_reg  <= PINS_IDLE;
        end
        else
        begin
            sync1_reg <= pins_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Edge events seen on the system clock
    assign sel       = ~sync2_reg.cs_n;
    assign sclk_rise = sel & sync2_reg.sclk & ~prev_reg.sclk;
    assign sclk_fall = sel & ~sync2_reg.sclk & prev_reg.sclk;
    assign cs_rise   = sync2_reg.cs_n & ~prev_reg.cs_n;
    assign in_byte   = {in_sh_reg[6:0], sync2_reg.din};      // [R22]
    assign byte_done = sclk_rise & (bitpos_reg == LAST_BIT);

    // Protection state and readable status
    assign hardware_lock_mode         = lock_reg & ~sync2_reg.wp_n;         // [R12] [R16] [R17]
    assign bp_clear    = (bp_reg == 3'h0);
    assign status_byte = {lock_reg, 2'b00, bp_reg, wel_reg, busy_reg}; // [R14] [R3] [R9]
    assign status_o    = status_byte;
    assign hw_lock_o   = hardware_lock_mode;
    assign sw_lock_o   = ~bp_clear;

    // Input shifter, MSB first
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            in_sh_reg <= 8'h00;
        end
        else if (sclk_rise)
        begin
            in_sh_reg <= in_byte;
        end
    end

    // Bit and byte counters, cleared while deselected
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bitpos_reg   <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end
        else if (!sel)
        begin
            bitpos_reg   <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end
        else if (sclk_rise)
        begin
            bitpos_reg <= bitpos_reg + 3'h1;
            if (byte_done && byte_cnt_reg != BYTE_SAT)
            begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
        end
    end

    // Command phase sequencer
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg  <= ST_OPCODE;
            opcode_reg <= 8'h00;
        end
        else if (!sel)
        begin
            state_reg <= ST_OPCODE;                          // [R20]
        end
        else if (byte_done)
        begin
            unique case (state_reg)
                ST_OPCODE:
                begin
                    opcode_reg <= in_byte;
                    unique case (in_byte)                    // [R24]
                        STATUS_READ_CMD:  state_reg <= ST_STATUS_OUT;   // [R7]
                        ARRAY_READ_CMD:   state_reg <= busy_reg ? ST_IGNORE : ST_ADDR; // [R21]
                        STATUS_WRITE_CMD: state_reg <= ST_WDATA;
                        default:          state_reg <= ST_TAIL;
                    endcase
                end
                ST_ADDR:
                begin
                    if (byte_cnt_reg == ADDR_END_BYTE)
                    begin
                        state_reg <= ST_DATA_OUT;            // [R18]
                    end
                end
                ST_WDATA:      state_reg <= ST_TAIL;
                ST_STATUS_OUT: state_reg <= ST_STATUS_OUT;
                ST_DATA_OUT:   state_reg <= ST_DATA_OUT;
                ST_TAIL:       state_reg <= ST_TAIL;
                ST_IGNORE:     state_reg <= ST_IGNORE;
            endcase
        end
    end

    // Address and status data capture
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            addr_reg  <= '0;
            wdata_reg <= 8'h00;
        end
        else
        begin
            if (sclk_rise && state_reg == ST_ADDR)
            begin
                addr_reg <= {addr_reg[ADDR_W-2:0], sync2_reg.din}; // [R18] [R22]
            end
            if (byte_done && state_reg == ST_WDATA)
            begin
                wdata_reg <= in_byte;
            end
        end
    end

    // Commands that execute on deselect, only at whole bytes
    assign aligned     = cs_rise & (bitpos_reg == 3'h0) & ~busy_reg;       // [R23]
    assign exec_set    = aligned & (opcode_reg == LATCH_SET_CMD) & (byte_cnt_reg == ONE_BYTE);
    assign exec_clear  = aligned & (opcode_reg == LATCH_CLEAR_CMD) & (byte_cnt_reg == ONE_BYTE);
    assign exec_status_write_cmd   = aligned & (state_reg == ST_TAIL) & (opcode_reg == STATUS_WRITE_CMD)
                       & (byte_cnt_reg == TWO_BYTES) & wel_reg & ~hardware_lock_mode;     // [R13] [R3] [R12]
    assign exec_modify = aligned & wel_reg & bp_clear                      // [R10] [R11] [R3]
                       & (((opcode_reg == PAGE_PROGRAM_CMD) && byte_cnt_reg >= PROG_MIN_BYTES)
                       || ((opcode_reg == SECTOR_ERASE_CMD) && byte_cnt_reg == ERASE_BYTES)
                       || ((opcode_reg == BLOCK_ERASE_CMD) && byte_cnt_reg == ERASE_BYTES)
                       || ((opcode_reg == CHIP_ERASE_CMD) && byte_cnt_reg == ONE_BYTE));
    assign start_cycle = exec_status_write_cmd | exec_modify;
    assign busy_end    = busy_reg & (busy_cnt_reg == '0);

    // Self-timed internal cycle
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            busy_reg     <= 1'b0;
            busy_cnt_reg <= '0;
            pend_wr_reg  <= 1'b0;
        end
        else if (start_cycle)
        begin
            busy_reg     <= 1'b1;                            // [R9] [R15]
            busy_cnt_reg <= BUSY_W'(BUSY_CYCLES - 1);
            pend_wr_reg  <= exec_status_write_cmd;
        end
        else if (busy_end)
        begin
            busy_reg    <= 1'b0;
            pend_wr_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
    end

    // Write enable latch
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wel_reg <= 1'b0;                                 // [R6]
        end
        else if (busy_end)
        begin
            wel_reg <= 1'b0;                                 // [R6] [R15]
        end
        else if (exec_set)
        begin
            wel_reg <= 1'b1;                                 // [R1]
        end
        else if (exec_clear)
        begin
            wel_reg <= 1'b0;                                 // [R5]
        end
    end

    // Lock and protect bits, cleared by reset, committed at cycle end
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            lock_reg <= STATUS_RESET[LOCK_BIT];
            bp_reg   <= STATUS_RESET[BP_MSB:BP_LSB];
        end
        else if (busy_end && pend_wr_reg)
        begin
            lock_reg <= wdata_reg[LOCK_BIT];                 // [R14]
            bp_reg   <= wdata_reg[BP_MSB:BP_LSB];            // [R10]
        end
    end

    // Array storage with preload port
    always_ff @(posedge clk_i)
    begin
        if (mem_wr_i)
        begin
            array_mem[mem_addr_i] <= mem_data_i;
        end
    end

    // Prefetch address, increments with wrap per buffered byte
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            fetch_addr_reg <= '0;
        end
        else if (byte_done && state_reg == ST_ADDR && byte_cnt_reg == ADDR_END_BYTE)
        begin
            fetch_addr_reg <= {addr_reg[ADDR_W-2:0], sync2_reg.din};
        end
        else if (state_reg == ST_DATA_OUT && buf_in_ready)
        begin
            fetch_addr_reg <= fetch_addr_reg + 1'b1;         // [R19]
        end
    end

    // Two-entry buffer between array fetch and shifter
    flash_byte_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) read_buf (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (!sel),
        .in_valid_i  (state_reg == ST_DATA_OUT),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (array_mem[fetch_addr_reg[MEM_AW-1:0]]),
        .out_valid_o (buf_out_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_out_data)
    );

    // Output phase selection
    assign out_phase     = (state_reg == ST_STATUS_OUT) | (state_reg == ST_DATA_OUT);
    assign pop           = sclk_fall & (state_reg == ST_DATA_OUT) & (out_cnt_reg == 3'h0);
    assign next_byte     = (state_reg == ST_STATUS_OUT) ? status_byte :
                           (buf_out_valid ? buf_out_data : 8'h00);
    assign data_out_en_o = sel & out_phase;
    assign data_out_o    = dout_reg;

    // Output shifter on falling clock, MSB first
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            out_sh_reg  <= 8'h00;
            out_cnt_reg <= 3'h0;
            dout_reg    <= 1'b0;
        end
        else if (!sel)
        begin
            out_cnt_reg <= 3'h0;                             // [R20]
        end
        else if (sclk_fall && out_phase)
        begin
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h0)
            begin
                dout_reg   <= next_byte[7];                  // [R7] [R18] [R22]
                out_sh_reg <= {next_byte[6:0], 1'b0};
            end
            else
            begin
                dout_reg   <= out_sh_reg[7];
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end

    // Checks on the command behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence status_write_cmd_frame_s;
        cs_rise && state_reg == ST_TAIL && opcode_reg == STATUS_WRITE_CMD && byte_cnt_reg == TWO_BYTES
        && bitpos_reg == 3'h0 && !busy_reg;
    endsequence

    latch_set_a: assert property (exec_set |=> wel_reg)                            // [R1]
        else $error("latch set command did not set latch");
    latch_clear_a: assert property (exec_clear |=> !wel_reg)                       // [R5]
        else $error("latch clear command did not clear latch");
    wel_gate_a: assert property (status_write_cmd_frame_s ##0 !wel_reg |=> !busy_reg)          // [R3]
        else $error("status write ran with latch clear");
    hw_lock_a: assert property (status_write_cmd_frame_s ##0 hardware_lock_mode |=> !busy_reg)                // [R12]
        else $error("status write ran in hardware lock");
    status_write_cmd_start_a: assert property (status_write_cmd_frame_s ##0 (wel_reg && !hardware_lock_mode) |=> busy_reg && status_o[WIP_BIT]) // [R15]
        else $error("accepted status write did not start cycle");
    cycle_end_a: assert property ($fell(busy_reg) |-> !wel_reg)                    // [R6]
        else $error("latch still set after cycle end");
    chip_guard_a: assert property (aligned && opcode_reg == CHIP_ERASE_CMD && !bp_clear |=> !busy_reg) // [R11]
        else $error("chip erase ran with protect bits set");
    zero_bits_a: assert property (status_o[6:5] == 2'b00 && status_o[WIP_BIT] == busy_reg) // [R14]
        else $error("status reserved bits not zero");
    read_reject_a: assert property (byte_done && state_reg == ST_OPCODE && in_byte == ARRAY_READ_CMD
                                    && busy_reg |=> state_reg == ST_IGNORE)        // [R21]
        else $error("array read not refused while busy");
    status_any_a: assert property (byte_done && state_reg == ST_OPCODE && in_byte == STATUS_READ_CMD
                                   |=> state_reg == ST_STATUS_OUT)                 // [R7]
        else $error("status read not accepted");
    deselect_a: assert property (cs_rise |=> state_reg == ST_OPCODE && !data_out_en_o) // [R20]
        else $error("deselect did not end command");
    addr_wrap_a: assert property (state_reg == ST_DATA_OUT && buf_in_ready && fetch_addr_reg == '1
                                  && sel |=> fetch_addr_reg == '0)                 // [R19]
        else $error("read address did not wrap to zero");
endmodule : serial_flash_status_read

// ===== sim/spi_host_model.sv
module spi_host_model (
    input  wire logic            clk_i,  // System clock
    input  wire logic            data_i, // Device serial out
    output flash_cmd_pkg::pins_t pins_o  // Select, clock, data, protect
);
    timeunit 1ns;
    timeprecision 100ps;
    import flash_cmd_pkg::*;

    // Idle pins, link clock parked low
    initial pins_o = PINS_IDLE;

    // Wait n edges, then step just past the last
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // Protect pin level, then let it settle
    task automatic set_wp(input logic v);
        pins_o.wp_n <= v;
        tick(8);
    endtask : set_wp

    // One framed transfer of n bits, MSB first, 80 ns link clock
    task automatic send(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        pins_o.cs_n <= 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            pins_o.din <= tx[i];
            tick(4);
            rx[i] = data_i;
            pins_o.sclk <= 1'b1;
            tick(4);
            pins_o.sclk <= 1'b0;
        end
        tick(4);
        pins_o.cs_n <= 1'b1;
        pins_o.din  <= ~pins_o.din; // Data line inverted
        tick(4);
    endtask : send
endmodule : spi_host_model

// ===== sim/tb_serial_flash_status_protect_read.sv
module tb_serial_flash_status_protect_read;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_cmd_pkg::*;

    logic        clk_i;
    logic        reset_i;
    logic        mem_wr;
    logic [11:0] mem_addr;
    logic [7:0]  mem_data;
    logic        en_seen  = 1'b0;
    pins_t       pins;
    logic        dout, dout_en, hw_lock, sw_lock;
    logic [7:0]  status, st;
    logic [63:0] rx;
    int          err_total = 0;
    int          tests_run = 0;

    always #5 clk_i = ~clk_i;

    serial_flash_status_read #(.BUSY_CYCLES(700)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins), .data_out_o(dout),
        .data_out_en_o(dout_en), .mem_wr_i(mem_wr), .mem_addr_i(mem_addr),
        .mem_data_i(mem_data), .status_o(status), .hw_lock_o(hw_lock), .sw_lock_o(sw_lock));

    spi_host_model host (.clk_i(clk_i), .data_i(dout), .pins_o(pins));

    // Sticky flag: device drove its output
    always @(posedge clk_i)
        if (dout_en === 1'b1)
            en_seen <= 1'b1;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic cmd(input logic [7:0] op);
        host.send({56'h0, op}, 8, rx);
    endtask : cmd

    task automatic rd_status;
        host.send({48'h0, STATUS_READ_CMD, 8'h00}, 16, rx);
        st = rx[7:0];
    endtask : rd_status

    task automatic wr_status(input logic [7:0] d);
        cmd(LATCH_SET_CMD);
        host.send({48'h0, STATUS_WRITE_CMD, d}, 16, rx);
    endtask : wr_status

    // Poll busy bit, bounded
    task automatic wait_idle;
        for (int i = 0; i < 20; i++)
        begin
            rd_status();
            if (st[WIP_BIT] === 1'b0)
                return;
        end
        check(16'hFFFF, 16'h0000);
    endtask : wait_idle

    task automatic mem_put(input logic [11:0] a, input logic [7:0] d);
        mem_addr <= a;
        mem_data <= d;
        mem_wr   <= 1'b1;
        host.tick(1);
        mem_wr   <= 1'b0;
    endtask : mem_put

    task automatic t_latch;
        rd_status();
        check({8'h0, st}, 16'h0000);
        cmd(LATCH_SET_CMD);
        rd_status();
        check({8'h0, st}, 16'h0002);
        host.send({49'h0, STATUS_WRITE_CMD, 7'h4E}, 15, rx);
        rd_status();
        check({8'h0, st}, 16'h0002);
        cmd(LATCH_CLEAR_CMD);
        host.send({57'h0, 7'h03}, 7, rx);
        rd_status();
        check({8'h0, st}, 16'h0000);
        host.send({48'h0, STATUS_WRITE_CMD, 8'hFF}, 16, rx);
        rd_status();
        check({8'h0, st}, 16'h0000);
    endtask : t_latch

    task automatic t_protect;
        wr_status(8'hFF);
        rd_status();
        check({8'h0, st}, 16'h0003);
        wait_idle();
        check({st, status}, 16'h9C9C);
        cmd(LATCH_SET_CMD);
        host.send({32'h0, SECTOR_ERASE_CMD, 24'h000100}, 32, rx);
        rd_status();
        check({8'h0, st}, 16'h009E);
        host.set_wp(1'b0);
        check({14'h0, hw_lock, sw_lock}, 16'h0003);
        wr_status(8'h00);
        cmd(CHIP_ERASE_CMD);
        rd_status();
        check({8'h0, st & 8'hFD}, 16'h009C);
        host.set_wp(1'b1);
        check({15'h0, hw_lock}, 16'h0000);
        wr_status(8'h80);
        wait_idle();
        check({8'h0, st}, 16'h0080);
        host.set_wp(1'b0);
        check({15'h0, hw_lock}, 16'h0001);
        host.set_wp(1'b1);
        wr_status(8'h08);
        wait_idle();
        host.set_wp(1'b0);
        wr_status(8'h00);
        wait_idle();
        check({8'h0, st}, 16'h0000);
        host.set_wp(1'b1);
    endtask : t_protect

    task automatic t_busy;
        cmd(LATCH_SET_CMD);
        cmd(CHIP_ERASE_CMD);
        host.send({40'h0, STATUS_READ_CMD, 16'h0}, 24, rx);
        check(rx[15:0], 16'h0303);
        en_seen = 1'b0;
        host.send({24'h0, ARRAY_READ_CMD, 24'h0, 8'h0}, 40, rx);
        check({15'h0, en_seen}, 16'h0000);
        wait_idle();
        check({8'h0, st}, 16'h0000);
    endtask : t_busy

    // Sector and block erase run a timed cycle when unprotected
    task automatic t_erase;
        cmd(LATCH_SET_CMD);
        host.send({32'h0, SECTOR_ERASE_CMD, 24'h000100}, 32, rx);
        rd_status();
        check({8'h0, st}, 16'h0003);
        wait_idle();
        check({8'h0, st}, 16'h0000);
        cmd(LATCH_SET_CMD);
        host.send({32'h0, BLOCK_ERASE_CMD, 24'h010000}, 32, rx);
        rd_status();
        check({8'h0, st}, 16'h0003);
        wait_idle();
        check({8'h0, st}, 16'h0000);
    endtask : t_erase

    task automatic t_array;
        mem_put(12'hFFF, 8'hA5);
        mem_put(12'h000, 8'h3C);
        mem_put(12'h001, 8'h81);
        host.send({16'h0, ARRAY_READ_CMD, 24'hFFFFFF, 16'h0}, 48, rx);
        check(rx[15:0], 16'hA53C);
        host.send({21'h0, ARRAY_READ_CMD, 24'h000001, 3'h0}, 35, rx);
        check({12'h0, dout_en, rx[2:0]}, 16'h0004);
        rd_status();
        check({8'h0, st}, 16'h0000);
    endtask : t_array

    // Reset, then scenarios in order
    initial
    begin
        clk_i    = 1'b0;
        reset_i  = 1'b1;
        mem_wr   = 1'b0;
        mem_addr = '0;
        mem_data = '0;
        host.tick(3);
        reset_i <= 1'b0;
        host.tick(6);
        t_latch();
        t_protect();
        t_busy();
        t_erase();
        t_array();
        final_report();
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        final_report();
    end
endmodule : tb_serial_flash_status_protect_read
